// ==== rtl/amt_top.v ====
`timescale 1ns/10ps
`default_nettype none
`include "amt_defines.vh"

// Contract
// RQ1: with the monitor enabled, the selected result is compared with the comparison value, smaller or larger.
// RQ2: compare_select codes 0 to 7 pick result pairs 0 to 7 and any code with the top bit set picks the priority pair.
// RQ3: bit 7 of the trigger register picks timer9_event_a (0) or timer9_event_b (1) for priority conversion.
// RQ4: bit 6 of the trigger register lets the chosen timer event start a priority conversion.
// RQ5: bit 5 of the trigger register picks timer0_event_a (0) or timer0_event_b (1) for normal conversion.
// RQ6: bit 4 of the trigger register lets the chosen timer event start a normal conversion.
// RQ7: writing 10 then 01 to the reset field reinitialises every register of the block; rdata_ff, the two start registers and monitor_irq_ff are not cleared.
// RQ8: software selects the trigger source, then enables it, then starts the timer.
// RQ9: software never sets up priority and normal conversion at the same moment.
// RQ10: a result keeps its two low bits in bits 7 and 6 of the low byte and its upper eight in the high byte.
// RQ11: bits 5 to 2 of every low result byte read as ones.
// RQ12: bit 0 of a low byte is set on a store and cleared by reading that low byte.
// RQ13: bit 1 of a low byte is set when a store overwrites a pair not fully read, and cleared by reading it.
// RQ14: software reads the high byte of a pair before its low byte.
// RQ15: the monitor is evaluated on each store into the selected pair and gives a one-cycle request.
module amt_top (
    input wire clk_sys,
    input wire rstn,
    input wire [31:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output wire [7:0] bus_rdata,
    input wire result_valid,
    input wire [3:0] result_index,
    input wire [9:0] result_data,
    input wire [9:0] compare_value,
    input wire timer9_event_a,
    input wire timer9_event_b,
    input wire timer0_event_a,
    input wire timer0_event_b,
    output wire priority_hw_start,
    output wire normal_hw_start,
    output wire monitor_irq,
    output wire core_soft_reset
);

    reg [7:0] rdata_ff;
    reg [7:0] nxt_rdata;
    reg monitor_enable_ff;
    reg monitor_direction_ff;
    reg [3:0] compare_select_ff;
    reg priority_trigger_source_ff;
    reg priority_trigger_enable_ff;
    reg normal_trigger_source_ff;
    reg normal_trigger_enable_ff;
    reg srst_armed_ff;
    reg soft_reset_ff;
    reg priority_start_ff;
    reg normal_start_ff;
    reg monitor_irq_ff;

    wire pair_page_hit;
    wire [3:0] pair_index;
    wire pair_hit;
    wire wr_monitor;
    wire wr_trigger;
    wire [1:0] srst_field;
    wire srst_fire;
    wire [3:0] monitor_target;
    wire monitor_hit;
    wire value_smaller;
    wire value_larger;
    wire priority_event;
    wire normal_event;

    wire [7:0] low_byte [0:8];
    wire [7:0] high_byte [0:8];

    // pair decode: base page, then two bytes per pair
    assign pair_page_hit = (bus_addr[31:5] == `AMT_PAIR_PAGE);
    assign pair_index = bus_addr[4:1];
    assign pair_hit = pair_page_hit && (pair_index <= `AMT_PAIR_LAST);

    assign wr_monitor = bus_wr && (bus_addr == `AMT_MONITOR_CONTROL);
    assign wr_trigger = bus_wr && (bus_addr == `AMT_TRIGGER_AND_SOFT_RESET);
    assign srst_field = bus_wdata[`AMT_SRST_MSB:`AMT_SRST_LSB];

    // the second half only counts straight after the first
    assign srst_fire = wr_trigger && srst_armed_ff && (srst_field == `AMT_SRST_SECOND); // RQ7

    genvar gi;
    generate
        for (gi = 0; gi < `AMT_PAIR_COUNT; gi = gi + 1) begin : g_pair
            wire sel;
            wire store;
            assign sel = pair_hit && (pair_index == gi);
            assign store = result_valid && (result_index == gi);
            amt_result_pair u_pair (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .soft_clear(soft_reset_ff), // RQ7
                .store(store),
                .store_value(result_data),
                .rd_low(bus_rd && sel && !bus_addr[0]), // RQ12 RQ13
                .rd_high(bus_rd && sel && bus_addr[0]),
                .value(),
                .low_byte(low_byte[gi]),
                .high_byte(high_byte[gi])
            );
        end
    endgenerate

    // monitor looks at the incoming value as it lands in the selected pair
    assign monitor_target = compare_select_ff[3] ? `AMT_PAIR_PRIO : {1'b0, compare_select_ff[2:0]}; // RQ2
    assign monitor_hit = monitor_enable_ff && result_valid && (result_index == monitor_target); // RQ15
    assign value_smaller = (result_data < compare_value);
    assign value_larger = (result_data > compare_value);

    assign priority_event = priority_trigger_source_ff ? timer9_event_b : timer9_event_a; // RQ3
    assign normal_event = normal_trigger_source_ff ? timer0_event_b : timer0_event_a; // RQ5

    always @* begin
        nxt_rdata = 8'h00;
        if (bus_rd) begin
            if (pair_hit) begin
                nxt_rdata = bus_addr[0] ? high_byte[pair_index] : low_byte[pair_index];
            end else if (bus_addr == `AMT_MONITOR_CONTROL) begin
                nxt_rdata = {2'b00, monitor_direction_ff, compare_select_ff, monitor_enable_ff};
            end else if (bus_addr == `AMT_TRIGGER_AND_SOFT_RESET) begin
                nxt_rdata = {priority_trigger_source_ff, priority_trigger_enable_ff,
                             normal_trigger_source_ff, normal_trigger_enable_ff,
                             3'b000, srst_armed_ff};
            end
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            monitor_enable_ff <= 1'b0;
            monitor_direction_ff <= 1'b0;
            compare_select_ff <= 4'h0;
        end else if (soft_reset_ff) begin
            monitor_enable_ff <= 1'b0; // RQ7
            monitor_direction_ff <= 1'b0;
            compare_select_ff <= 4'h0;
        end else if (wr_monitor) begin
            monitor_enable_ff <= bus_wdata[`AMT_MON_ENABLE_BIT];
            monitor_direction_ff <= bus_wdata[`AMT_MON_DIRECTION_BIT];
            compare_select_ff <= bus_wdata[`AMT_MON_SELECT_MSB:`AMT_MON_SELECT_LSB];
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            priority_trigger_source_ff <= 1'b0;
            priority_trigger_enable_ff <= 1'b0;
            normal_trigger_source_ff <= 1'b0;
            normal_trigger_enable_ff <= 1'b0;
        end else if (soft_reset_ff) begin
            priority_trigger_source_ff <= 1'b0; // RQ7
            priority_trigger_enable_ff <= 1'b0;
            normal_trigger_source_ff <= 1'b0;
            normal_trigger_enable_ff <= 1'b0;
        end else if (wr_trigger) begin
            priority_trigger_source_ff <= bus_wdata[`AMT_TRG_PRIO_SOURCE_BIT];
            priority_trigger_enable_ff <= bus_wdata[`AMT_TRG_PRIO_ENABLE_BIT];
            normal_trigger_source_ff <= bus_wdata[`AMT_TRG_NORM_SOURCE_BIT];
            normal_trigger_enable_ff <= bus_wdata[`AMT_TRG_NORM_ENABLE_BIT];
        end
    end

    // any other write to the register breaks the two-step sequence
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            srst_armed_ff <= 1'b0;
            soft_reset_ff <= 1'b0;
        end else begin
            soft_reset_ff <= srst_fire; // RQ7
            if (wr_trigger) begin
                srst_armed_ff <= (srst_field == `AMT_SRST_FIRST); // RQ7
            end else if (soft_reset_ff) begin
                srst_armed_ff <= 1'b0;
            end
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            priority_start_ff <= 1'b0;
            normal_start_ff <= 1'b0;
            monitor_irq_ff <= 1'b0;
        end else begin
            priority_start_ff <= priority_trigger_enable_ff && priority_event; // RQ4
            normal_start_ff <= normal_trigger_enable_ff && normal_event; // RQ6
            monitor_irq_ff <= monitor_hit && (monitor_direction_ff ? value_larger : value_smaller); // RQ1 RQ15
        end
    end

    assign bus_rdata = rdata_ff;
    assign priority_hw_start = priority_start_ff;
    assign normal_hw_start = normal_start_ff;
    assign monitor_irq = monitor_irq_ff;
    assign core_soft_reset = soft_reset_ff;

endmodule

`default_nettype wire

// ==== rtl/amt_defines.vh ====
`ifndef AMT_DEFINES_VH
`define AMT_DEFINES_VH

// register bus
`define AMT_ADDR_W 32
`define AMT_DATA_W 8

// result pairs: low byte at base + 2*pair, high byte one above
`define AMT_PAIR_PAGE 27'h7ffff98
`define AMT_PAIR_COUNT 9
`define AMT_PAIR_PRIO 4'h8
`define AMT_PAIR_LAST 4'h8
`define AMT_RESULT_PAIR2_LOW 32'hfffff304
`define AMT_RESULT_PAIR2_HIGH 32'hfffff305
`define AMT_RESULT_PAIR3_LOW 32'hfffff306
`define AMT_RESULT_PAIR3_HIGH 32'hfffff307
`define AMT_RESULT_PRIO_LOW 32'hfffff310
`define AMT_RESULT_PRIO_HIGH 32'hfffff311

// control registers
`define AMT_MONITOR_CONTROL 32'hfffff317
`define AMT_TRIGGER_AND_SOFT_RESET 32'hfffff318
`define AMT_MONITOR_CONTROL_RST 8'h00
`define AMT_TRIGGER_RST 8'h00

// monitor_control fields
`define AMT_MON_ENABLE_BIT 0
`define AMT_MON_SELECT_LSB 1
`define AMT_MON_SELECT_MSB 4
`define AMT_MON_DIRECTION_BIT 5

// trigger_and_soft_reset fields
`define AMT_TRG_PRIO_SOURCE_BIT 7
`define AMT_TRG_PRIO_ENABLE_BIT 6
`define AMT_TRG_NORM_SOURCE_BIT 5
`define AMT_TRG_NORM_ENABLE_BIT 4
`define AMT_SRST_LSB 0
`define AMT_SRST_MSB 1
`define AMT_SRST_FIRST 2'h2
`define AMT_SRST_SECOND 2'h1

// lower result byte layout
`define AMT_LOW_ONES 4'hf
`define AMT_LOW_PRESENT_BIT 0
`define AMT_LOW_OVERRUN_BIT 1

`endif

// ==== rtl/amt_result_pair.v ====
`timescale 1ns/10ps
`default_nettype none
`include "amt_defines.vh"

module amt_result_pair (
    input wire clk_sys,
    input wire rstn,
    input wire soft_clear,
    input wire store,
    input wire [9:0] store_value,
    input wire rd_low,
    input wire rd_high,
    output wire [9:0] value,
    output wire [7:0] low_byte,
    output wire [7:0] high_byte
);

    reg [9:0] value_ff;
    reg present_ff;
    reg overrun_ff;
    reg held_ff;
    reg high_seen_ff;
    reg low_seen_ff;
    reg [9:0] nxt_value;
    reg nxt_present;
    reg nxt_overrun;
    reg nxt_held;
    reg nxt_high_seen;
    reg nxt_low_seen;

    always @* begin
        nxt_value = value_ff;
        nxt_present = present_ff;
        nxt_overrun = overrun_ff;
        nxt_held = held_ff;
        nxt_high_seen = high_seen_ff | rd_high;
        nxt_low_seen = low_seen_ff | rd_low;
        if (rd_low) begin
            nxt_present = 1'b0; // RQ12
            nxt_overrun = 1'b0; // RQ13
        end
        // a store in the same cycle as a read wins over the clear
        if (store) begin
            nxt_value = store_value;
            nxt_present = 1'b1; // RQ12
            nxt_held = 1'b1;
            nxt_high_seen = 1'b0;
            nxt_low_seen = 1'b0;
            if (held_ff && !(high_seen_ff && low_seen_ff)) begin
                nxt_overrun = 1'b1; // RQ13
            end
        end
        if (soft_clear) begin
            nxt_value = 10'h000;
            nxt_present = 1'b0;
            nxt_overrun = 1'b0;
            nxt_held = 1'b0;
            nxt_high_seen = 1'b0;
            nxt_low_seen = 1'b0;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            value_ff <= 10'h000;
            present_ff <= 1'b0;
            overrun_ff <= 1'b0;
            held_ff <= 1'b0;
            high_seen_ff <= 1'b0;
            low_seen_ff <= 1'b0;
        end else begin
            value_ff <= nxt_value;
            present_ff <= nxt_present;
            overrun_ff <= nxt_overrun;
            held_ff <= nxt_held;
            high_seen_ff <= nxt_high_seen;
            low_seen_ff <= nxt_low_seen;
        end
    end

    assign value = value_ff;
    assign low_byte = {value_ff[1:0], `AMT_LOW_ONES, overrun_ff, present_ff}; // RQ10 RQ11
    assign high_byte = value_ff[9:2]; // RQ10

endmodule

`default_nettype wire

// ==== bench/amt_top_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "amt_defines.vh"
module amt_top_checker (
    input wire clk_sys,
    input wire rstn,
    input wire [31:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    input wire [7:0] bus_rdata,
    input wire result_valid,
    input wire [3:0] result_index,
    input wire [9:0] result_data,
    input wire [9:0] compare_value,
    input wire timer9_event_a,
    input wire timer9_event_b,
    input wire timer0_event_a,
    input wire timer0_event_b,
    input wire priority_hw_start,
    input wire normal_hw_start,
    input wire monitor_irq,
    input wire core_soft_reset
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire rd_low = bus_rd && bus_addr[31:5] == `AMT_PAIR_PAGE && !bus_addr[0] && bus_addr[4:1] <= `AMT_PAIR_LAST;
    property p_ones; rd_low |=> bus_rdata[5:2] == 4'hf; endproperty
    a_ones: assert property (p_ones) else $error("filler bits");
    property p_pst; priority_hw_start |-> $past(timer9_event_a || timer9_event_b); endproperty
    a_pst: assert property (p_pst) else $error("stray priority start");
    property p_nst; normal_hw_start |-> $past(timer0_event_a || timer0_event_b); endproperty
    a_nst: assert property (p_nst) else $error("stray normal start");
    property p_irq; monitor_irq |-> $past(result_valid && result_data != compare_value); endproperty
    a_irq: assert property (p_irq) else $error("irq without store");
    property p_bad; result_valid && result_index > `AMT_PAIR_LAST |=> !monitor_irq; endproperty
    a_bad: assert property (p_bad) else $error("irq on bad index");
    property p_srst;
        core_soft_reset |-> $past(bus_wr && bus_addr == `AMT_TRIGGER_AND_SOFT_RESET && bus_wdata[1:0] == 2'h1);
    endproperty
    a_srst: assert property (p_srst) else $error("stray soft reset");
    // a second read of a low byte with no store between sees both flags clear
    property p_clr;
        rd_low && !result_valid ##1 !result_valid ##1 bus_rd && bus_addr == $past(bus_addr, 2) && !result_valid
        |=> bus_rdata[1:0] == 2'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("flags kept");
    property p_set;
        result_valid && !core_soft_reset ##1 !result_valid && !core_soft_reset
        ##1 rd_low && !core_soft_reset && bus_addr[4:1] == $past(result_index, 2)
        |=> bus_rdata[0] && bus_rdata[7:6] == $past(result_data[1:0], 3);
    endproperty
    a_set: assert property (p_set) else $error("store not seen");
    c_irq: cover property (monitor_irq);
    c_srst: cover property (core_soft_reset);
    c_pst: cover property (priority_hw_start);
endmodule
bind amt_top amt_top_checker u_amt_top_checker (
    .clk_sys(clk_sys), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .result_valid(result_valid), .result_index(result_index), .result_data(result_data),
    .compare_value(compare_value),
    .timer9_event_a(timer9_event_a), .timer9_event_b(timer9_event_b),
    .timer0_event_a(timer0_event_a), .timer0_event_b(timer0_event_b),
    .priority_hw_start(priority_hw_start), .normal_hw_start(normal_hw_start),
    .monitor_irq(monitor_irq), .core_soft_reset(core_soft_reset)
);
`default_nettype wire

// ==== bench/amt_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module amt_core_model (
    input wire logic clk_sys,
    output var logic result_valid,
    output var logic [3:0] result_index,
    output var logic [9:0] result_data,
    output var logic [3:0] timer_ev
);
    initial begin
        result_valid = 1'b0;
        result_index = 4'h0;
        result_data = 10'h000;
        timer_ev = 4'h0;
    end
    // idle values are scrambled so nothing can lean on stale data
    task store(input logic [3:0] idx, input logic [9:0] v);
        @(posedge clk_sys);
        result_valid <= 1'b1;
        result_index <= idx;
        result_data <= v;
        @(posedge clk_sys);
        result_valid <= 1'b0;
        result_index <= ~idx;
        result_data <= ~v;
    endtask
    // 0,1 timer9 a/b; 2,3 timer0 a/b
    task pulse(input int n);
        @(posedge clk_sys);
        timer_ev[n] <= 1'b1;
        @(posedge clk_sys);
        timer_ev[n] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== bench/adc_monitor_trigger_result_regs_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "amt_defines.vh"
module adc_monitor_trigger_result_regs_tb;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] bus_addr = 32'h0;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [9:0] compare_value = 10'h200;
    logic [3:0] cfg;
    logic [3:0] p;
    logic [9:0] v;
    wire [7:0] bus_rdata;
    wire result_valid;
    wire [3:0] result_index;
    wire [9:0] result_data;
    wire [3:0] ev;
    wire prio_st;
    wire norm_st;
    wire monitor_irq;
    wire core_soft_reset;
    int err_total = 0;
    int checked = 0;
    localparam logic [31:0] MON = `AMT_MONITOR_CONTROL;
    localparam logic [31:0] TRG = `AMT_TRIGGER_AND_SOFT_RESET;
    localparam logic [31:0] P3L = `AMT_RESULT_PAIR3_LOW;
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    amt_core_model u_amt_core_model (.clk_sys(clk_sys), .result_valid(result_valid),
        .result_index(result_index), .result_data(result_data), .timer_ev(ev));
    amt_top u_amt_top (.clk_sys(clk_sys), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .result_valid(result_valid),
        .result_index(result_index), .result_data(result_data), .compare_value(compare_value),
        .timer9_event_a(ev[0]), .timer9_event_b(ev[1]), .timer0_event_a(ev[2]), .timer0_event_b(ev[3]),
        .priority_hw_start(prio_st), .normal_hw_start(norm_st), .monitor_irq(monitor_irq),
        .core_soft_reset(core_soft_reset));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask
    task rd(input logic [31:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1 chk(bus_rdata, exp);
    endtask
    task st(input logic [3:0] idx, input logic [9:0] d, input logic irq);
        u_amt_core_model.store(idx, d);
        #1 chk({7'h0, monitor_irq}, {7'h0, irq});
    endtask
    function automatic logic [7:0] lowb(input logic [9:0] d, input logic o, input logic r);
        return {d[1:0], 4'hf, o, r};
    endfunction
    task end_of_test;
        $display("checked %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        err_total++;
        end_of_test;
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(MON, 8'h00);
        rd(`AMT_RESULT_PAIR2_LOW, 8'h3c);
        rd(`AMT_RESULT_PAIR2_HIGH, 8'h00);
        rd(32'hfffff31f, 8'h00);
        // one side at a time, source before enable
        for (int k = 0; k < 8; k++) begin
            cfg = k[2] ? {k[1], k[0], 2'b00} : {2'b00, k[1], k[0]};
            wr(TRG, {cfg & 4'ha, 4'h0});
            wr(TRG, {cfg, 4'h0});
            rd(TRG, {cfg, 4'h0});
            for (int j = 0; j < 4; j++) begin
                u_amt_core_model.pulse(j);
                #1 chk({6'h0, prio_st, norm_st}, {6'h0, j < 2 && cfg[2] && cfg[3] == j[0],
                    j >= 2 && cfg[0] && cfg[1] == j[0]});
            end
        end
        for (int s = 0; s < 32; s++) begin
            p = s[3] ? 4'h8 : s[3:0];
            v = s[4] ? 10'h201 : 10'h1ff;
            wr(MON, {2'b00, s[4], s[3:0], 1'b1});
            rd(MON, {2'b00, s[4], s[3:0], 1'b1});
            st(p, v, 1'b1);
            st(p, 10'h200, 1'b0);
            st(p, ~v & 10'h3ff ^ 10'h1fe, 1'b0);
            st(p == 4'h8 ? 4'h0 : p + 4'h1, v, 1'b0);
            st(s[0] ? 4'h9 : 4'hf, v, 1'b0);
        end
        wr(MON, 8'h00);
        st(4'h0, 10'h000, 1'b0);
        // monitor armed on pair 3, larger: only the soft reset keeps the next store quiet
        wr(MON, 8'h27);
        wr(TRG, 8'h42);
        rd(TRG, 8'h41);
        wr(TRG, 8'h40);
        wr(TRG, 8'h41);
        #1 chk({7'h0, core_soft_reset}, 8'h00);
        wr(TRG, 8'h42);
        wr(TRG, 8'h41);
        #1 chk({7'h0, core_soft_reset}, 8'h01);
        rd(TRG, 8'h00);
        rd(MON, 8'h00);
        rd(P3L, 8'h3c);
        st(4'h3, 10'h2a5, 1'b0);
        rd(`AMT_RESULT_PAIR3_HIGH, 8'ha9);
        rd(P3L, lowb(10'h2a5, 1'b0, 1'b1));
        rd(P3L, lowb(10'h2a5, 1'b0, 1'b0));
        st(4'h3, 10'h15a, 1'b0);
        rd(P3L, lowb(10'h15a, 1'b0, 1'b1));
        st(4'h3, 10'h3ff, 1'b0);
        rd(`AMT_RESULT_PAIR3_HIGH, 8'hff);
        rd(P3L, 8'hff);
        wr(P3L, 8'h00);
        rd(P3L, 8'hfc);
        st(4'h8, 10'h0c3, 1'b0);
        rd(`AMT_RESULT_PRIO_HIGH, 8'h30);
        rd(`AMT_RESULT_PRIO_LOW, lowb(10'h0c3, 1'b0, 1'b1));
        end_of_test;
    end
endmodule
`default_nettype wire
